// ==== include/ihs_pkg.sv ====
// Package: register map, reset values and field layout of the home shift and alarm log block
package ihs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int unsigned ALM_DEPTH = 6;
	localparam int unsigned ALM_W = 8;
	localparam int unsigned STS_W = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_HOME_SHIFT = 8'h04;
	localparam logic [7:0] ADDR_INPOS_RANGE = 8'h08;
	localparam logic [7:0] ADDR_ROUGH_RANGE = 8'h0C;
	localparam logic [7:0] ADDR_ALM_CLEAR = 8'h10;
	localparam logic [7:0] ADDR_TORQUE_DELAY = 8'h14;
	localparam logic [7:0] ADDR_AUTO_ON = 8'h18;
	localparam logic [7:0] ADDR_POLARITY = 8'h1C;
	localparam logic [7:0] ADDR_RESPONSE = 8'h20;
	localparam logic [7:0] ADDR_FUNC_ONE = 8'h24;
	localparam logic [7:0] ADDR_FUNC_FIVE = 8'h28;
	localparam logic [7:0] ADDR_STATUS = 8'h2C;
	localparam logic [7:0] ADDR_MASK = 8'h30;
	localparam logic [7:0] ADDR_ALM_BASE = 8'h34;
	localparam logic [7:0] ADDR_STATE = 8'h4C;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned CTRL_PWR_CYCLE = 0;
	localparam int unsigned CTRL_ABS_MODE = 1;
	localparam int unsigned STS_ALARM = 0;
	localparam int unsigned STS_ROUGH = 1;
	localparam int unsigned STS_INPOS = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Values after reset and limits
	localparam logic [15:0] RST_HOME_SHIFT = 16'h0000;
	localparam logic [15:0] RST_INPOS_RANGE = 16'h0064;
	localparam logic [15:0] RST_ROUGH_RANGE = 16'h0000;
	localparam logic [15:0] RST_TORQUE_DELAY = 16'h0064;
	localparam logic [15:0] RST_AUTO_ON = 16'h0000;
	localparam logic [15:0] RST_POLARITY = 16'h0000;
	localparam logic [15:0] RST_RESPONSE = 16'h0002;
	localparam logic [15:0] RST_FUNC_ONE = 16'h0010;
	localparam logic [15:0] RST_FUNC_FIVE = 16'h0000;
	localparam logic signed [15:0] SHIFT_MIN = -16'sd2000;
	localparam logic signed [15:0] SHIFT_MAX = 16'sd2000;

endpackage : ihs_pkg

// ==== include/ihs_alarm_if.sv ====
// Interface: link between the register logic and the alarm history store
`timescale 1ns/1ps
interface ihs_alarm_if;
	import ihs_pkg::*;
	logic rec;
	logic [ALM_W-1:0] code;
	logic clr;
	logic [ALM_DEPTH-1:0][ALM_W-1:0] entry;
	logic [2:0] count;
	modport owner (output rec, output code, output clr, input entry, input count);
	modport hist (input rec, input code, input clr, output entry, output count);
endinterface : ihs_alarm_if

// ==== hw/ihs_alarm_hist.sv ====
// Alarm history store: one current alarm and five past alarms
`timescale 1ns/1ps
module ihs_alarm_hist
	import ihs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Record and clear
	ihs_alarm_if.hist io
);

	typedef struct packed {
		logic [ALM_DEPTH-1:0][ALM_W-1:0] entry;
		logic [2:0] count;
	} ihs_hist_st_t;

	ihs_hist_st_t s;
	ihs_hist_st_t next_s;

	////////////////////////////////////////////////////////////////////////////////
	// Clear has priority; a record in the same cycle is dropped with the old log
	always_comb begin
		next_s = s;
		if (io.clr) begin
			next_s.entry = '0; // RULE6
			next_s.count = 3'h0;
		end else if (io.rec) begin
			for (int i = ALM_DEPTH - 1; i > 0; i--) begin
				next_s.entry[i] = s.entry[i-1]; // RULE12
			end
			next_s.entry[0] = io.code;
			if (s.count != 3'(ALM_DEPTH)) begin
				next_s.count = s.count + 3'h1; // RULE5
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign io.entry = s.entry;
	assign io.count = s.count;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_hist_depth;
		io.rec && !io.clr && s.count == 3'(ALM_DEPTH) |=> s.count == 3'(ALM_DEPTH);
	endproperty
	a_hist_depth: assert property (p_hist_depth) else $error("history count left full"); // RULE5

	property p_hist_shift;
		io.rec && !io.clr |=> s.entry[0] == $past(io.code) && s.entry[5] == $past(s.entry[4]);
	endproperty
	a_hist_shift: assert property (p_hist_shift) else $error("history did not shift"); // RULE12

	property p_hist_clear;
		io.clr |=> s.count == 3'h0 && s.entry[0] == '0;
	endproperty
	a_hist_clear: assert property (p_hist_clear) else $error("history not erased"); // RULE6

	c_hist_full: cover property (io.rec && s.count == 3'(ALM_DEPTH));

endmodule : ihs_alarm_hist

// ==== hw/ihs_top.sv ====
// Indexer home shift, in-position, rough match and alarm log logic with APB registers
//
// Overview of operation
// RULE1: Home shift applied only in absolute position mode, else zero.
// RULE2: Home shift is signed pulses, -2000 to 2000, reset zero.
// RULE3: New home shift used only after the next power cycle.
// RULE4: Shift larger than in-position range keeps in-position low at power-on.
// RULE5: Log holds one current and five past alarms since first power-on.
// RULE6: Clear field: 0 keeps history, 1 erases all entries.
// RULE7: After clearing, the clear field returns to zero by itself.
// RULE8: Clear request acts only at the next power cycle.
// RULE9: Rough match asserts once remaining distance is within the rough range.
// RULE10: Rough match range is unsigned 0 to 65535 pulses.
// RULE11: Torque limit delay resets to 0064h.
// RULE12: Full log drops the oldest past alarm; newest becomes current.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module ihs_top
	import ihs_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Drive logic, same clock
	input wire logic ALARM_VALID,
	input wire logic [ALM_W-1:0] ALARM_CODE,
	input wire logic [31:0] REMAIN_DIST,
	input wire logic signed [31:0] POS_ERROR,
	// Status outputs
	output logic IN_POSITION_OUT,
	output logic ROUGH_MATCH_OUT,
	output logic IRQ,
	// Settings to the drive
	output logic signed [15:0] HOME_SHIFT_APPLIED,
	output logic [15:0] TORQUE_LIMIT_DELAY,
	output logic [15:0] INPUT_AUTO_ON_SELECT,
	output logic [15:0] INPUT_POLARITY_SELECT,
	output logic [15:0] INPUT_RESPONSE_LEVEL,
	output logic [15:0] FUNCTION_SELECT_ONE,
	output logic [15:0] FUNCTION_SELECT_FIVE
);

	typedef struct packed {
		logic abs_mode;
		logic pwr_req;
		logic signed [15:0] home_shift;
		logic signed [15:0] shift_applied;
		logic shift_block;
		logic [15:0] inpos_range;
		logic [15:0] rough_range;
		logic alm_clear;
		logic [15:0] torque_delay;
		logic [15:0] auto_on;
		logic [15:0] polarity;
		logic [15:0] response;
		logic [15:0] func_one;
		logic [15:0] func_five;
		logic [STS_W-1:0] status;
		logic [STS_W-1:0] mask;
		logic [STS_W-1:0] rd_sts;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic in_pos;
		logic rough;
		logic irq;
	} ihs_st_t;

	ihs_st_t s;
	ihs_st_t next_s;
	ihs_alarm_if alm ();

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [31:0] ihs_mag(input logic signed [31:0] v);
		ihs_mag = v[31] ? 32'(-v) : 32'(v);
	endfunction : ihs_mag

	function automatic logic ihs_hit(input logic [7:0] a);
		ihs_hit = (a[1:0] == 2'h0) && (a <= ADDR_STATE);
	endfunction : ihs_hit

	function automatic logic ihs_shift_ok(input logic [15:0] v);
		ihs_shift_ok = ($signed(v) >= SHIFT_MIN) && ($signed(v) <= SHIFT_MAX);
	endfunction : ihs_shift_ok

	localparam ihs_st_t ST_RESET = '{
		abs_mode: 1'b0, pwr_req: 1'b0,
		home_shift: RST_HOME_SHIFT, shift_applied: RST_HOME_SHIFT, shift_block: 1'b0,
		inpos_range: RST_INPOS_RANGE, rough_range: RST_ROUGH_RANGE, alm_clear: 1'b0,
		torque_delay: RST_TORQUE_DELAY, auto_on: RST_AUTO_ON, polarity: RST_POLARITY,
		response: RST_RESPONSE, func_one: RST_FUNC_ONE, func_five: RST_FUNC_FIVE,
		status: '0, mask: '0, rd_sts: '0, prdata: 32'h0000_0000,
		pready: 1'b0, pslverr: 1'b0, in_pos: 1'b0, rough: 1'b0, irq: 1'b0
	};

	logic setup;
	logic access;
	logic [31:0] rd_data;
	logic [STS_W-1:0] events;

	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE && s.pready;

	////////////////////////////////////////////////////////////////////////////////
	// Read mux

	always_comb begin
		rd_data = 32'h0000_0000;
		case (PADDR)
			ADDR_CTRL: rd_data[CTRL_ABS_MODE] = s.abs_mode;
			ADDR_HOME_SHIFT: rd_data = {{16{s.home_shift[15]}}, s.home_shift};
			ADDR_INPOS_RANGE: rd_data[15:0] = s.inpos_range;
			ADDR_ROUGH_RANGE: rd_data[15:0] = s.rough_range;
			ADDR_ALM_CLEAR: rd_data[0] = s.alm_clear;
			ADDR_TORQUE_DELAY: rd_data[15:0] = s.torque_delay;
			ADDR_AUTO_ON: rd_data[15:0] = s.auto_on;
			ADDR_POLARITY: rd_data[15:0] = s.polarity;
			ADDR_RESPONSE: rd_data[15:0] = s.response;
			ADDR_FUNC_ONE: rd_data[15:0] = s.func_one;
			ADDR_FUNC_FIVE: rd_data[15:0] = s.func_five;
			ADDR_STATUS: rd_data[STS_W-1:0] = s.status;
			ADDR_MASK: rd_data[STS_W-1:0] = s.mask;
			ADDR_STATE: rd_data = {s.shift_applied, 12'h000, s.shift_block, alm.count};
			default: begin
				for (int i = 0; i < ALM_DEPTH; i++) begin
					if (PADDR == ADDR_ALM_BASE + 8'(4 * i)) begin
						rd_data[ALM_W-1:0] = alm.entry[i];
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;
		next_s.pwr_req = 1'b0;
		// Zero wait: pready follows the setup cycle
		next_s.pready = setup;
		if (setup) begin
			next_s.prdata = rd_data;
			next_s.pslverr = !ihs_hit(PADDR)
				|| (PWRITE && PADDR == ADDR_HOME_SHIFT && !ihs_shift_ok(PWDATA[15:0])); // RULE2
			next_s.rd_sts = (!PWRITE && PADDR == ADDR_STATUS) ? s.status : '0;
		end
		if (access && PWRITE && !s.pslverr) begin
			case (PADDR)
				ADDR_CTRL: begin
					next_s.abs_mode = PWDATA[CTRL_ABS_MODE];
					next_s.pwr_req = PWDATA[CTRL_PWR_CYCLE];
				end
				ADDR_HOME_SHIFT: next_s.home_shift = PWDATA[15:0]; // RULE2
				ADDR_INPOS_RANGE: next_s.inpos_range = PWDATA[15:0];
				ADDR_ROUGH_RANGE: next_s.rough_range = PWDATA[15:0]; // RULE10
				ADDR_ALM_CLEAR: next_s.alm_clear = PWDATA[0]; // RULE6
				ADDR_TORQUE_DELAY: next_s.torque_delay = PWDATA[15:0];
				ADDR_AUTO_ON: next_s.auto_on = PWDATA[15:0];
				ADDR_POLARITY: next_s.polarity = PWDATA[15:0];
				ADDR_RESPONSE: next_s.response = PWDATA[15:0];
				ADDR_FUNC_ONE: next_s.func_one = PWDATA[15:0];
				ADDR_FUNC_FIVE: next_s.func_five = PWDATA[15:0];
				ADDR_MASK: next_s.mask = PWDATA[STS_W-1:0];
				default: next_s.mask = s.mask;
			endcase
		end

		// Soft power cycle: pending settings take effect only here
		if (s.pwr_req) begin
			next_s.shift_applied = s.abs_mode ? s.home_shift : 16'sh0000; // RULE1 RULE3
			next_s.shift_block = s.abs_mode
				&& ihs_mag(32'(s.home_shift)) > {16'h0000, s.inpos_range}; // RULE4
			if (s.alm_clear) begin
				next_s.alm_clear = 1'b0; // RULE7
			end
		end else if (REMAIN_DIST != 32'h0000_0000) begin
			// First commanded move releases the power-on hold
			next_s.shift_block = 1'b0;
		end

		next_s.rough = REMAIN_DIST <= {16'h0000, s.rough_range}; // RULE9
		next_s.in_pos = !next_s.shift_block
			&& ihs_mag(POS_ERROR) <= {16'h0000, s.inpos_range}; // RULE4

		// Only bits the read returned are cleared, so a late event survives
		events = '0;
		events[STS_ALARM] = ALARM_VALID;
		events[STS_ROUGH] = next_s.rough && !s.rough;
		events[STS_INPOS] = next_s.in_pos && !s.in_pos;
		next_s.status = (s.status & ~((access && !PWRITE) ? s.rd_sts : '0)) | events;
		next_s.irq = |(next_s.status & next_s.mask);
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			s <= ST_RESET; // RULE11
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Alarm history

	assign alm.rec = ALARM_VALID;
	assign alm.code = ALARM_CODE;
	assign alm.clr = s.pwr_req && s.alm_clear; // RULE8

	ihs_alarm_hist u_hist (
		.clk(CLK),
		.rst_b(RST_B),
		.io(alm.hist)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign PRDATA = s.prdata;
	assign PREADY = s.pready;
	assign PSLVERR = s.pslverr;
	assign IN_POSITION_OUT = s.in_pos;
	assign ROUGH_MATCH_OUT = s.rough;
	assign IRQ = s.irq;
	assign HOME_SHIFT_APPLIED = s.shift_applied;
	assign TORQUE_LIMIT_DELAY = s.torque_delay;
	assign INPUT_AUTO_ON_SELECT = s.auto_on;
	assign INPUT_POLARITY_SELECT = s.polarity;
	assign INPUT_RESPONSE_LEVEL = s.response;
	assign FUNCTION_SELECT_ONE = s.func_one;
	assign FUNCTION_SELECT_FIVE = s.func_five;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	property p_shift_abs;
		s.pwr_req |=> HOME_SHIFT_APPLIED == ($past(s.abs_mode) ? $past(s.home_shift) : 16'sh0000);
	endproperty
	a_shift_abs: assert property (p_shift_abs) else $error("applied shift wrong after cycle"); // RULE1

	property p_shift_range;
		$signed(s.home_shift) >= SHIFT_MIN && $signed(s.home_shift) <= SHIFT_MAX;
	endproperty
	a_shift_range: assert property (p_shift_range) else $error("home shift out of range"); // RULE2

	property p_shift_hold;
		!s.pwr_req |=> $stable(HOME_SHIFT_APPLIED);
	endproperty
	a_shift_hold: assert property (p_shift_hold) else $error("shift applied without cycle"); // RULE3

	property p_inpos_block;
		s.pwr_req && s.abs_mode && ihs_mag(32'(s.home_shift)) > {16'h0000, s.inpos_range}
			|-> ##1 !IN_POSITION_OUT;
	endproperty
	a_inpos_block: assert property (p_inpos_block) else $error("in-position high at power-on"); // RULE4

	property p_clear_self;
		s.pwr_req && s.alm_clear && !(PSEL && PENABLE && PWRITE) |=> !s.alm_clear;
	endproperty
	a_clear_self: assert property (p_clear_self) else $error("clear field did not return"); // RULE7

	property p_clear_wait;
		!s.pwr_req |=> alm.count >= $past(alm.count);
	endproperty
	a_clear_wait: assert property (p_clear_wait) else $error("history cleared early"); // RULE8

	property p_rough;
		REMAIN_DIST <= {16'h0000, s.rough_range} |=> ROUGH_MATCH_OUT;
	endproperty
	a_rough: assert property (p_rough) else $error("rough match missing"); // RULE9

	property p_rough_off;
		REMAIN_DIST > {16'h0000, s.rough_range} |=> !ROUGH_MATCH_OUT;
	endproperty
	a_rough_off: assert property (p_rough_off) else $error("rough match too early"); // RULE9

	property p_torque_reset;
		@(posedge CLK) disable iff (1'b0) !RST_B |=> TORQUE_LIMIT_DELAY == RST_TORQUE_DELAY;
	endproperty
	a_torque_reset: assert property (p_torque_reset) else $error("torque delay reset wrong"); // RULE11

	property p_irq;
		ALARM_VALID && s.mask[STS_ALARM] |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("masked-in alarm gave no interrupt");

	c_pwr_clear: cover property (s.pwr_req && s.alm_clear);
	c_rough_rise: cover property (!ROUGH_MATCH_OUT ##1 ROUGH_MATCH_OUT);
	c_block: cover property (s.shift_block ##1 !s.shift_block);
	c_irq: cover property (IRQ ##[1:4] !IRQ);

endmodule : ihs_top

// ==== verif/ihs_drive_model.sv ====
// Drive side model: alarm events, remaining distance and position error
`timescale 1ns/1ps
module ihs_drive_model
	import ihs_pkg::*;
(
	// Clock
	input wire logic clk,
	// Drive outputs
	output logic alarm_valid,
	output logic [ALM_W-1:0] alarm_code,
	output logic [31:0] remain_dist,
	output logic signed [31:0] pos_error
);
	initial begin
		alarm_valid = 1'b0;
		alarm_code = 8'h00;
		remain_dist = 32'h0000_0000;
		pos_error = 32'sh0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One-cycle alarm pulse; code inverted after it so stale codes are not trusted
	task automatic alarm(input logic [ALM_W-1:0] c);
		@(posedge clk);
		alarm_valid <= 1'b1;
		alarm_code <= c;
		@(posedge clk);
		alarm_valid <= 1'b0;
		alarm_code <= ~c;
	endtask : alarm
	// Remaining distance is unsigned pulses
	task automatic move(input logic [31:0] d);
		@(posedge clk);
		remain_dist <= d;
	endtask : move
	// Signed position error as the feedback loop reports it
	task automatic follow(input logic signed [31:0] e);
		@(posedge clk);
		pos_error <= e;
	endtask : follow
endmodule : ihs_drive_model

// ==== verif/ihs_tb_top.sv ====
// Testbench: APB master, scenarios for home shift, alarm log, rough match
`timescale 1ns/1ps
module ihs_tb_top;
	import ihs_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, alarm_valid, in_pos, rough, irq;
	logic [ALM_W-1:0] alarm_code;
	logic [31:0] remain_dist;
	logic signed [31:0] pos_error;
	logic signed [15:0] shift_applied;
	logic [15:0] torque_delay;
	logic [15:0] auto_on, polarity, response, func_one, func_five;
	int miscompares = 0;
	int total_checks = 0;
	always #50 clk = ~clk;
	ihs_drive_model ihs_drive_model_i (.clk(clk), .alarm_valid(alarm_valid),
		.alarm_code(alarm_code), .remain_dist(remain_dist), .pos_error(pos_error));
	ihs_top ihs_top_i (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .ALARM_VALID(alarm_valid),
		.ALARM_CODE(alarm_code), .REMAIN_DIST(remain_dist), .POS_ERROR(pos_error),
		.IN_POSITION_OUT(in_pos), .ROUGH_MATCH_OUT(rough), .IRQ(irq),
		.HOME_SHIFT_APPLIED(shift_applied), .TORQUE_LIMIT_DELAY(torque_delay),
		.INPUT_AUTO_ON_SELECT(auto_on), .INPUT_POLARITY_SELECT(polarity),
		.INPUT_RESPONSE_LEVEL(response), .FUNCTION_SELECT_ONE(func_one),
		.FUNCTION_SELECT_FIVE(func_five));
	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// Slave latency is not assumed; wait for pready under a bound
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			$display("[FAIL] pready expected 1 seen %b", pready);
			miscompares++;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, d, r, e);
		chk("write error", {31'h0, exp_err}, {31'h0, e});
	endtask : wr
	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		xfer(1'b0, a, 32'h0000_0000, r, e);
		chk(what, exp, r & m);
	endtask : rd
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rd("torque delay", ADDR_TORQUE_DELAY, 32'hFFFF_FFFF, 32'h0000_0064);
		chk("torque port", 32'h0000_0064, {16'h0, torque_delay});
		rd("home shift", ADDR_HOME_SHIFT, 32'hFFFF_FFFF, 32'h0000_0000);
		rd("response", ADDR_RESPONSE, 32'hFFFF_FFFF, 32'h0000_0002);
		rd("func one", ADDR_FUNC_ONE, 32'hFFFF_FFFF, 32'h0000_0010);
		chk("auto on port", 32'h0000_0000, {16'h0, auto_on});
		chk("polarity port", 32'h0000_0000, {16'h0, polarity});
		chk("response port", 32'h0000_0002, {16'h0, response});
		chk("func one port", 32'h0000_0010, {16'h0, func_one});
		chk("func five port", 32'h0000_0000, {16'h0, func_five});
		wr(ADDR_AUTO_ON, 32'h0000_0A5A, 1'b0);
		wr(ADDR_POLARITY, 32'h0000_0F0F, 1'b0);
		wr(ADDR_RESPONSE, 32'h0000_0003, 1'b0);
		wr(ADDR_FUNC_ONE, 32'h0000_0001, 1'b0);
		wr(ADDR_FUNC_FIVE, 32'h0000_1234, 1'b0);
		cyc(1);
		chk("auto on written", 32'h0000_0A5A, {16'h0, auto_on});
		chk("polarity written", 32'h0000_0F0F, {16'h0, polarity});
		chk("response written", 32'h0000_0003, {16'h0, response});
		chk("func one written", 32'h0000_0001, {16'h0, func_one});
		chk("func five written", 32'h0000_1234, {16'h0, func_five});
		wr(8'h50, 32'h0000_0001, 1'b1);
		rd("unmapped", 8'h50, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask : t_reset
	task automatic t_shift();
		wr(ADDR_HOME_SHIFT, 32'h0000_07D1, 1'b1);
		wr(ADDR_HOME_SHIFT, 32'hFFFF_F830, 1'b0);
		rd("shift", ADDR_HOME_SHIFT, 32'hFFFF_FFFF, 32'hFFFF_F830);
		chk("applied early", 32'h0, {16'h0, shift_applied});
		wr(ADDR_CTRL, 32'h0000_0001, 1'b0);
		cyc(2);
		chk("applied no abs", 32'h0, {16'h0, shift_applied});
		wr(ADDR_CTRL, 32'h0000_0002, 1'b0);
		cyc(2);
		chk("applied before cycle", 32'h0, {16'h0, shift_applied});
		wr(ADDR_CTRL, 32'h0000_0003, 1'b0);
		cyc(2);
		chk("in position at power-on", 32'h0, {31'h0, in_pos});
		cyc(1);
		chk("applied abs", 32'h0000_F830, {16'h0, shift_applied});
		chk("in position held", 32'h0, {31'h0, in_pos});
		ihs_drive_model_i.move(32'h0000_0005);
		ihs_drive_model_i.move(32'h0000_0000);
		cyc(3);
		chk("in position after move", 32'h1, {31'h0, in_pos});
		ihs_drive_model_i.follow(32'sd101);
		cyc(3);
		chk("in position beyond range", 32'h0, {31'h0, in_pos});
		ihs_drive_model_i.follow(-32'sd100);
		cyc(3);
		chk("in position at range", 32'h1, {31'h0, in_pos});
	endtask : t_shift
	task automatic t_alarm();
		wr(ADDR_MASK, 32'h0000_0001, 1'b0);
		rd("status flush", ADDR_STATUS, 32'h7, 32'h6);
		for (int i = 0; i < 7; i++) begin
			ihs_drive_model_i.alarm(8'h11 + 8'(i));
		end
		cyc(2);
		chk("irq set", 32'h1, {31'h0, irq});
		for (int i = 0; i < 6; i++) begin
			rd("entry", ADDR_ALM_BASE + 8'(4 * i), 32'hFF, {24'h0, 8'h17 - 8'(i)});
		end
		rd("count", ADDR_STATE, 32'h7, 32'h6);
		rd("status alarm", ADDR_STATUS, 32'h1, 32'h1);
		cyc(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(ADDR_MASK, 32'h0000_0000, 1'b0);
		ihs_drive_model_i.alarm(8'h18);
		cyc(2);
		chk("irq masked", 32'h0, {31'h0, irq});
		rd("status masked", ADDR_STATUS, 32'h1, 32'h1);
	endtask : t_alarm
	task automatic t_clear();
		wr(ADDR_ALM_CLEAR, 32'h0000_0001, 1'b0);
		rd("clear field", ADDR_ALM_CLEAR, 32'h1, 32'h1);
		rd("entry kept", ADDR_ALM_BASE, 32'hFF, 32'h18);
		wr(ADDR_CTRL, 32'h0000_0003, 1'b0);
		cyc(3);
		rd("clear returns", ADDR_ALM_CLEAR, 32'h1, 32'h0);
		rd("entry erased", ADDR_ALM_BASE, 32'hFF, 32'h0);
		rd("count erased", ADDR_STATE, 32'h7, 32'h0);
	endtask : t_clear
	task automatic t_rough();
		wr(ADDR_ROUGH_RANGE, 32'h0000_000A, 1'b0);
		ihs_drive_model_i.move(32'h0000_000B);
		cyc(3);
		chk("rough above", 32'h0, {31'h0, rough});
		ihs_drive_model_i.move(32'h0000_000A);
		cyc(3);
		chk("rough at range", 32'h1, {31'h0, rough});
		wr(ADDR_ROUGH_RANGE, 32'h0000_FFFF, 1'b0);
		rd("rough max", ADDR_ROUGH_RANGE, 32'hFFFF_FFFF, 32'h0000_FFFF);
		ihs_drive_model_i.move(32'h0001_0000);
		cyc(3);
		chk("rough beyond max", 32'h0, {31'h0, rough});
		ihs_drive_model_i.move(32'h0000_FFFF);
		cyc(3);
		chk("rough at max", 32'h1, {31'h0, rough});
	endtask : t_rough
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		cyc(3);
		rst_b <= 1'b1;
		t_reset();
		t_shift();
		t_alarm();
		t_clear();
		t_rough();
		end_of_test();
	end
	initial begin
		#(100 * 5000);
		$display("[FAIL] watchdog expected end seen timeout");
		miscompares++;
		end_of_test();
	end
endmodule : ihs_tb_top
